// [rtl/uep_top.sv]
// Module: endpoint-0 OUT buffer control, function address and event status
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module uep_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [7:0]        reg_rdata_o,
    input  wire logic              tok_valid_i,
    input  wire logic [6:0]        tok_addr_i,
    input  wire logic [3:0]        tok_ep_i,
    input  wire logic              tok_out_i,
    input  wire logic              tok_setup_i,
    input  wire logic              data_ok_i,
    input  wire logic [3:0]        data_len_i,
    input  wire logic              evt_bus_reset_i,
    input  wire logic              evt_suspend_i,
    input  wire logic              evt_resume_i,
    input  wire logic              evt_pwr_off_i,
    input  wire logic              evt_pwr_on_i,
    output logic                   hs_ack_o,
    output logic                   hs_nak_o,
    output logic                   ep0_out_full_o,
    output logic      [3:0]        ep0_out_count_o,
    output logic                   usb_irq_o
);
    import uep_pkg::*;

    // Four registers need at least two index bits
    if (ADDR_W < 2 || ADDR_W > 8) begin : g_bad_addr_w
        $error("uep_top: ADDR_W must be 2 to 8");
    end

    // ============================================================
    // Helpers
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs[ADDR_W-1:0]);
    endfunction

    function automatic logic [3:0] sat_count(input logic [3:0] c);
        sat_count = (c > OUT_CNT_MAX) ? OUT_CNT_MAX : c;
    endfunction

    // ============================================================
    // Register decode
    logic wr_cnt;
    logic wr_addr;
    logic wr_sta;
    logic wr_mask;
    assign wr_cnt  = reg_wr_i && reg_hit(reg_addr_i, OFS_EP0_OUT_CNT);
    assign wr_addr = reg_wr_i && reg_hit(reg_addr_i, OFS_FUNC_ADDR);
    assign wr_sta  = reg_wr_i && reg_hit(reg_addr_i, OFS_EVT_STATUS);
    assign wr_mask = reg_wr_i && reg_hit(reg_addr_i, OFS_EVT_MASK);

    logic [6:0]  func_addr_ff;
    logic [7:0]  mask_ff;
    logic [7:0]  sta_flags;
    uep_state_t  state_ff;

    // ============================================================
    // Token filter: other addresses and endpoints are ignored
    logic tok_ours;
    assign tok_ours = tok_valid_i && (tok_addr_i == func_addr_ff) && (tok_ep_i == EP_ZERO);

    logic out_load;
    logic setup_load;
    logic out_nak;
    assign out_load   = (state_ff == UEP_OUT_DATA) && data_ok_i;
    assign setup_load = (state_ff == UEP_SET_DATA) && data_ok_i;
    assign out_nak    = (state_ff == UEP_IDLE) && tok_ours && !tok_setup_i && tok_out_i && ep0_out_full_o;

    // ============================================================
    // Transaction sequencer
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= UEP_IDLE;
        end else begin
            case (state_ff)
                UEP_IDLE: begin
                    if (tok_ours && tok_setup_i) begin
                        state_ff <= UEP_SET_DATA;
                    end else if (tok_ours && tok_out_i && !ep0_out_full_o) begin
                        state_ff <= UEP_OUT_DATA;
                    end
                end
                UEP_OUT_DATA, UEP_SET_DATA: begin
                    // A fresh token means the data phase was lost
                    if (data_ok_i || tok_valid_i) begin
                        state_ff <= UEP_IDLE;
                    end
                end
                default: begin
                    state_ff <= UEP_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Handshake pulses
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hs_ack_o <= 1'b0;
            hs_nak_o <= 1'b0;
        end else begin
            hs_ack_o <= out_load || setup_load;
            hs_nak_o <= out_nak;
        end
    end

    // ============================================================
    // Endpoint-0 OUT count and buffer-full flag
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ep0_out_full_o  <= RST_OUT_FULL;
            ep0_out_count_o <= RST_OUT_CNT;
        end else if (out_load) begin
            // Hardware load wins over a firmware write in the same cycle
            ep0_out_full_o  <= 1'b1;
            ep0_out_count_o <= sat_count(data_len_i);
        end else if (wr_cnt) begin
            ep0_out_full_o  <= reg_wdata_i[BIT_OUT_FULL];
            ep0_out_count_o <= sat_count(reg_wdata_i[3:0]);
        end
    end

    // ============================================================
    // Function address and interrupt mask
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            func_addr_ff <= RST_FUNC_ADDR;
        end else if (wr_addr) begin
            func_addr_ff <= reg_wdata_i[6:0];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_ff <= RST_MASK;
        end else if (wr_mask) begin
            mask_ff <= reg_wdata_i;
        end
    end

    // ============================================================
    // Event status flags
    logic [7:0] sta_set;
    logic [7:0] sta_clr;
    always_comb begin
        sta_set                = 8'h00;
        sta_set[BIT_SETUP_OVWR] = setup_load && sta_flags[BIT_SETUP];
        sta_set[BIT_SETUP]     = setup_load;
        sta_set[BIT_PWR_ON]    = evt_pwr_on_i;
        sta_set[BIT_PWR_OFF]   = evt_pwr_off_i;
        sta_set[BIT_RESUME]    = evt_resume_i;
        sta_set[BIT_SUSPEND]   = evt_suspend_i;
        sta_set[BIT_BUS_RESET] = evt_bus_reset_i;
        sta_clr                = wr_sta ? reg_wdata_i : 8'h00;
    end

    uep_flag #(
        .W    (8),
        .IMPL (STATUS_IMPL)
    ) u_flags (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .set_i    (sta_set),
        .clr_i    (sta_clr),
        .flag_o   (sta_flags)
    );

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            usb_irq_o <= 1'b0;
        end else begin
            usb_irq_o <= |(sta_flags & mask_ff);
        end
    end

    // ============================================================
    // Read port, data one cycle after the strobe
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_hit(reg_addr_i, OFS_EP0_OUT_CNT)) begin
            reg_rdata_o <= {ep0_out_full_o, 3'b000, ep0_out_count_o};
        end else if (reg_hit(reg_addr_i, OFS_FUNC_ADDR)) begin
            reg_rdata_o <= {1'b0, func_addr_ff};
        end else if (reg_hit(reg_addr_i, OFS_EVT_STATUS)) begin
            reg_rdata_o <= sta_flags;
        end else if (reg_hit(reg_addr_i, OFS_EVT_MASK)) begin
            reg_rdata_o <= mask_ff;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_our_out_tok;
        state_ff == UEP_IDLE && tok_ours && tok_out_i && !tok_setup_i;
    endsequence

    sequence s_setup_again;
        setup_load && sta_flags[BIT_SETUP];
    endsequence

    property p_cnt_sat;
        out_load |=> ep0_out_count_o == (($past(data_len_i) > 4'h8) ? 4'h8 : $past(data_len_i));
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("count not saturated to 8");

    property p_out_accept;
        s_our_out_tok ##0 !ep0_out_full_o |=> state_ff == UEP_OUT_DATA && !hs_nak_o;
    endproperty
    a_out_accept: assert property (p_out_accept) else $error("empty buffer did not accept OUT");

    property p_out_nak;
        s_our_out_tok ##0 ep0_out_full_o |=> hs_nak_o && state_ff == UEP_IDLE;
    endproperty
    a_out_nak: assert property (p_out_nak) else $error("full buffer did not NAK");

    property p_addr_only;
        state_ff == UEP_IDLE && tok_valid_i && tok_addr_i != func_addr_ff |=> state_ff == UEP_IDLE && !hs_nak_o;
    endproperty
    a_addr_only: assert property (p_addr_only) else $error("foreign address answered");

    property p_w1c;
        wr_sta && sta_set == 8'h00 |=> sta_flags == ($past(sta_flags) & ~$past(reg_wdata_i));
    endproperty
    a_w1c: assert property (p_w1c) else $error("status write-1-clear wrong");

    property p_irq;
        |(sta_flags & mask_ff) |=> usb_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("masked-in flag raised no interrupt");

    property p_overwrite;
        s_setup_again |=> sta_flags[BIT_SETUP_OVWR] ##1 (sta_flags[BIT_SETUP_OVWR] || $past(wr_sta));
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("setup overwrite not flagged");

    property p_set_wins;
        (sta_set & sta_clr) != 8'h00 |=>
            (sta_flags & ($past(sta_set) & $past(sta_clr))) == ($past(sta_set) & $past(sta_clr));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a set");
endmodule
`default_nettype wire

// [rtl/uep_pkg.sv]
// Package: constants for the endpoint-0 OUT, function address and status block
// Notes on behaviour
// - The 4-bit endpoint-0 OUT count holds 0 to 8 in binary, and any code from 1001b to 1111b is taken as 8.
// - While the buffer-full flag is clear the buffer holds nothing valid and the next host OUT data is accepted.
// - While the buffer-full flag (bit 7, reset 1) is set, further host OUT transactions on endpoint 0 get a NAK.
// - Only traffic carrying the 7-bit function address in bits 6 to 0 is answered; reset zero, bit 7 reserved.
// - Status flags are set only by hardware; writing 1 clears a flag and writing 0 leaves it alone.
// - Each status flag raises the interrupt request while it is set and its mask bit is enabled.
// - The setup-overwrite flag (bit 0) is set when a setup packet arrives while the setup buffer is still full.
package uep_pkg;
    // ============================================================
    // Register offsets
    localparam logic [7:0] OFS_EP0_OUT_CNT = 8'h00;
    localparam logic [7:0] OFS_FUNC_ADDR   = 8'h01;
    localparam logic [7:0] OFS_EVT_STATUS  = 8'h02;
    localparam logic [7:0] OFS_EVT_MASK    = 8'h03;
    // ============================================================
    // Field positions
    localparam int BIT_OUT_FULL   = 7;
    localparam int BIT_SETUP_OVWR = 0;
    localparam int BIT_SETUP      = 2;
    localparam int BIT_PWR_ON     = 3;
    localparam int BIT_PWR_OFF    = 4;
    localparam int BIT_RESUME     = 5;
    localparam int BIT_SUSPEND    = 6;
    localparam int BIT_BUS_RESET  = 7;
    // ============================================================
    // Reset values and limits
    localparam logic       RST_OUT_FULL   = 1'b1;
    localparam logic [3:0] RST_OUT_CNT    = 4'h0;
    localparam logic [6:0] RST_FUNC_ADDR  = 7'h00;
    localparam logic [7:0] RST_STATUS     = 8'h00;
    localparam logic [7:0] RST_MASK       = 8'h00;
    localparam logic [3:0] OUT_CNT_MAX    = 4'h8;
    localparam logic [7:0] STATUS_IMPL    = 8'hFD;
    localparam logic [3:0] EP_ZERO        = 4'h0;
    // ============================================================
    // Transaction states, Gray along idle -> data -> idle
    typedef enum logic [1:0] {
        UEP_IDLE     = 2'b00,
        UEP_OUT_DATA = 2'b01,
        UEP_SET_DATA = 2'b10
    } uep_state_t;
endpackage

// [rtl/uep_flag.sv]
// Module: bank of write-1-to-clear event flags with set priority
`timescale 1ns/10ps
`default_nettype none
module uep_flag #(
    parameter int         W    = 8,
    parameter logic [7:0] IMPL = 8'hFF
) (
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flag_o
);
    // Mask parameter is one byte wide
    if (W < 1 || W > 8) begin : g_bad_w
        $error("uep_flag: W must be 1 to 8");
    end

    logic [W-1:0] flag_ff;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            if (IMPL[g]) begin : g_impl
                always_ff @(posedge mclk_i or negedge resetn_i) begin
                    if (!resetn_i) begin
                        flag_ff[g] <= 1'b0;
                    end else if (set_i[g]) begin
                        flag_ff[g] <= 1'b1;
                    end else if (clr_i[g]) begin
                        flag_ff[g] <= 1'b0;
                    end
                end
            end else begin : g_rsv
                assign flag_ff[g] = 1'b0;
            end
        end
    endgenerate

    assign flag_o = flag_ff;
endmodule
`default_nettype wire

// [verif/uep_host_model.sv]
// Partner model: USB host side sending tokens and data packets
`timescale 1ns/10ps
`default_nettype none
module uep_host_model (
    input  wire logic       mclk_i,
    output logic            tok_valid_o,
    output logic      [6:0] tok_addr_o,
    output logic      [3:0] tok_ep_o,
    output logic            tok_out_o,
    output logic            tok_setup_o,
    output logic            data_ok_o,
    output logic      [3:0] data_len_o
);
    // ============================================================
    // Requests, taken at the next edge
    logic       t_req  = 1'b0;
    logic       d_req  = 1'b0;
    logic [6:0] t_addr = 7'h00;
    logic [3:0] t_ep   = 4'h0;
    logic [1:0] t_kind = 2'b00;
    logic [3:0] d_len  = 4'h0;
    initial begin
        tok_valid_o = 1'b0;
        data_ok_o   = 1'b0;
        tok_addr_o  = 7'h55;
        tok_ep_o    = 4'h5;
        {tok_out_o, tok_setup_o} = 2'b01;
        data_len_o  = 4'hA;
    end
    // Fields scrambled off their strobe so stale values never look valid
    always @(posedge mclk_i) begin
        tok_valid_o <= t_req;
        data_ok_o   <= d_req;
        tok_addr_o  <= t_req ? t_addr : ~tok_addr_o;
        tok_ep_o    <= t_req ? t_ep : ~tok_ep_o;
        {tok_out_o, tok_setup_o} <= t_req ? t_kind : ~{tok_out_o, tok_setup_o};
        data_len_o  <= d_req ? d_len : ~data_len_o;
    end
    task automatic send_token(input logic [6:0] a, input logic [3:0] ep, input logic [1:0] kind);
        t_req  <= 1'b1;
        t_addr <= a;
        t_ep   <= ep;
        t_kind <= kind;
        @(posedge mclk_i);
        t_req  <= 1'b0;
        @(posedge mclk_i);
    endtask
    // Data only after its token; gap models a slow host
    task automatic send_data(input logic [3:0] len, input int gap);
        repeat (gap) @(posedge mclk_i);
        d_req <= 1'b1;
        d_len <= len;
        @(posedge mclk_i);
        d_req <= 1'b0;
        @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Testbench: register driver, host traffic, scoreboard and verdict
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import uep_pkg::*;
    // ============================================================
    // Signals
    logic       mclk_i      = 1'b0;
    logic       resetn_i    = 1'b0;
    logic       reg_wr_i    = 1'b0;
    logic       reg_rd_i    = 1'b0;
    logic       rd_d        = 1'b0;
    logic [7:0] reg_addr_i  = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [4:0] evt         = 5'h00;
    logic [7:0] reg_rdata_o;
    logic       tv, to, ts, dok, ack, nak, full, irq;
    logic [6:0] ta, addr;
    logic [3:0] tep, dlen, cnt, len;
    logic [7:0] ev;
    logic [4:0] n;
    logic [2:0] k;
    int         seed        = 8;
    int         mismatches  = 0;
    int         compares    = 0;
    logic [7:0] exp_rd[$];
    logic [1:0] exp_hs[$];
    always #50 mclk_i = ~mclk_i;
    uep_top u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tok_valid_i(tv), .tok_addr_i(ta),
        .tok_ep_i(tep), .tok_out_i(to), .tok_setup_i(ts), .data_ok_i(dok), .data_len_i(dlen),
        .evt_bus_reset_i(evt[4]), .evt_suspend_i(evt[3]), .evt_resume_i(evt[2]), .evt_pwr_off_i(evt[1]),
        .evt_pwr_on_i(evt[0]), .hs_ack_o(ack), .hs_nak_o(nak), .ep0_out_full_o(full),
        .ep0_out_count_o(cnt), .usb_irq_o(irq));
    uep_host_model u_host (.mclk_i(mclk_i), .tok_valid_o(tv), .tok_addr_o(ta), .tok_ep_o(tep), .tok_out_o(to),
        .tok_setup_o(ts), .data_ok_o(dok), .data_len_o(dlen));
    // ============================================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i    <= 1'b1;
        reg_rd_i    <= 1'b0;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_rd_i   <= 1'b1;
        reg_wr_i   <= 1'b0;
        reg_addr_i <= a;
        exp_rd.push_back(e);
        @(posedge mclk_i);
    endtask
    // Strobes must be low before host traffic, or a read repeats
    task automatic idle(input int cycles);
        reg_rd_i <= 1'b0;
        reg_wr_i <= 1'b0;
        evt      <= 5'h00;
        repeat (cycles) @(posedge mclk_i);
    endtask
    task automatic tok(input logic [6:0] a, input logic [3:0] ep, input logic [1:0] kind, input logic [1:0] hs);
        if (hs !== 2'b00)
            exp_hs.push_back(hs);
        u_host.send_token(a, ep, kind);
    endtask
    task automatic wrap_up;
        if (exp_rd.size() != 0 || exp_hs.size() != 0)
            mismatches++;
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ============================================================
    // Scoreboard: read data one cycle after the strobe, handshakes as they appear
    always @(posedge mclk_i) rd_d <= reg_rd_i;
    always @(negedge mclk_i) begin
        if (rd_d)
            check(reg_rdata_o, exp_rd.size() ? exp_rd.pop_front() : 8'hxx);
        if (ack | nak)
            check({6'h00, ack, nak}, exp_hs.size() ? {6'h00, exp_hs.pop_front()} : 8'hxx);
    end
    initial begin
        repeat (2000) @(posedge mclk_i);
        mismatches++;
        wrap_up;
    end
    // ============================================================
    // Scenarios
    initial begin
        idle(4);
        resetn_i <= 1'b1;
        idle(1);
        rd(OFS_EP0_OUT_CNT, 8'h80);
        rd(OFS_FUNC_ADDR, 8'h00);
        rd(OFS_EVT_STATUS, 8'h00);
        rd(8'h04, 8'h00);
        addr = 7'($random(seed));
        wr(OFS_FUNC_ADDR, {1'b1, addr});
        rd(OFS_FUNC_ADDR, {1'b0, addr});
        idle(1);
        tok(addr, EP_ZERO, 2'b10, 2'b01);
        wr(OFS_EP0_OUT_CNT, 8'h00);
        rd(OFS_EP0_OUT_CNT, 8'h00);
        idle(1);
        tok(addr ^ 7'h01, EP_ZERO, 2'b10, 2'b00);
        u_host.send_data(4'h3, 0);
        tok(addr, 4'h1, 2'b10, 2'b00);
        u_host.send_data(4'h3, 0);
        len = 4'($random(seed));
        ev  = {4'h8, (len > OUT_CNT_MAX) ? OUT_CNT_MAX : len};
        tok(addr, EP_ZERO, 2'b10, 2'b10);
        u_host.send_data(len, 2);
        idle(2);
        check({full, 3'h0, cnt}, ev);
        rd(OFS_EP0_OUT_CNT, ev);
        idle(1);
        tok(addr, EP_ZERO, 2'b10, 2'b01);
        for (n = 0; n < 16; n++) begin
            wr(OFS_EP0_OUT_CNT, {4'h0, n[3:0]});
            rd(OFS_EP0_OUT_CNT, {4'h0, (n > 8) ? OUT_CNT_MAX : n[3:0]});
        end
        idle(1);
        for (k = 0; k < 2; k++) begin
            tok(addr, EP_ZERO, 2'b01, 2'b10);
            u_host.send_data(4'h8, k);
            idle(2);
            rd(OFS_EVT_STATUS, {5'h00, 2'b10, k[0]});
            idle(1);
        end
        wr(OFS_EVT_STATUS, 8'h00);
        rd(OFS_EVT_STATUS, 8'h05);
        wr(OFS_EVT_STATUS, 8'h01);
        rd(OFS_EVT_STATUS, 8'h04);
        wr(OFS_EVT_STATUS, 8'h04);
        rd(OFS_EVT_STATUS, 8'h00);
        idle(1);
        for (k = 0; k < 5; k++) begin
            wr(OFS_EVT_MASK, k[0] ? 8'h00 : 8'h08 << k);
            idle(1);
            evt <= 5'h01 << k;
            @(posedge mclk_i);
            idle(3);
            check({7'h00, irq}, {7'h00, ~k[0]});
            rd(OFS_EVT_STATUS, 8'h08 << k);
            wr(OFS_EVT_STATUS, 8'h08 << k);
            idle(3);
            check({7'h00, irq}, 8'h00);
        end
        // Set and clear in one cycle: the event must survive
        evt <= 5'h10;
        wr(OFS_EVT_STATUS, 8'h80);
        idle(1);
        rd(OFS_EVT_STATUS, 8'h80);
        idle(2);
        wrap_up;
    end
endmodule
`default_nettype wire
